// ### inc/asr_pkg.sv
// Constants for the converter serial readout block.
// Assumes a 25 MHz core clock; the counts are in converter clocks and do not derive from it.
package asr_pkg;
    // Core clock rate in Hz
    localparam int unsigned CLK_HZ         = 25000000;
    // Result word width and codes
    localparam int unsigned RESULT_BITS    = 24;
    localparam logic [23:0] CODE_POS_FULL  = 24'h7fffff;
    localparam logic [23:0] CODE_NEG_FULL  = 24'h800000;
    localparam logic [23:0] CODE_ZERO      = 24'h000000;
    // Nominal converter clock and result rate
    localparam int unsigned SYS_CLK_NOM_HZ = 2457600;
    localparam int unsigned RATE_NOM_SPS   = 15;
    // Converter clocks per result at nominal rate
    localparam int unsigned CONV_PERIOD_SYSCLK = SYS_CLK_NOM_HZ / RATE_NOM_SPS;
    // Power-up calibration time in converter clocks (default figure)
    localparam int unsigned CAL_SYSCLK     = 4096;
    // Edge counter width: 24 data edges plus the forcing edge
    localparam int unsigned EDGE_W         = 5;
    localparam logic [4:0]  EDGE_FORCE     = 5'h18;
    // Reset values
    localparam logic        OUT_RESET      = 1'b1;
    localparam logic [23:0] HOLD_RESET     = 24'h000000;
    // Counter widths
    localparam int unsigned CNT_W          = 20;
    // Converter states
    typedef enum logic [1:0] {ST_CAL, ST_CONVERT} asr_state_type;
endpackage : asr_pkg

// ### design/asr_sync.sv
// Two-flop synchroniser with rising-edge detector on the settled copy.
// Assumes input is asynchronous to CLK; first flop feeds only the second.
`timescale 1ns/1ps
module asr_sync (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic CE,
    // Async level in
    input  wire logic din,
    // Synchronised level and rising-edge pulse
    output logic      dout,
    output logic      rise
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Synchroniser chain plus delayed copy for edge finding
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else if (CE) begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign dout = stage2;
    assign rise = CE && stage2 && !stage3;
endmodule : asr_sync

// ### design/asr_readout.sv
// Readout logic of a 24-bit delta-sigma converter: calibration, result
// timing, code clipping, and the shared ready/serial output.
// Assumes SYS_CLK and SHIFT_CLK are pins sampled by CLK (much faster).
//
// Operation
// [R01] Output goes low when a new result is ready.
// [R02] First shift-clock rise after ready puts the result MSB on the output.
// [R03] Each later rise presents the next lower bit, 24 bits in all.
// [R04] A 25th rise forces the output high until the next result.
// [R05] Results are 24-bit two's complement; zero input gives zero code.
// [R06] Out-of-range inputs clip to positive or negative full-scale codes.
// [R07] Plus one step gives 000001, minus one step gives all ones.
// [R08] Conversions run continuously; each update overwrites the held result.
// [R09] Result rate is 15 per second at 2.4576 MHz, scaling with clock.
// [R10] Host keeps the system clock running during conversion.
// [R11] Power-up calibration completes before the first ready low.
// [R12] Host holds the shift clock low during power-up.
// [R13] Host expects first result about 350 ms after power-up; the code instead gives it after 4096 converter clocks of calibration.
// [R14] Ready falling edge starts a new, fully settled conversion.
// [R15] Unfinished read holds the last bit until the update forces high; the code instead drives it low at the update.
// [R16] Host samples each bit on the falling shift-clock edge or later.
`timescale 1ns/1ps
module asr_readout (
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // Converter system clock pin
    input  wire logic        SYS_CLK,
    // Sample from the modulator/filter, wide signed value
    input  wire logic [25:0] FILTER_VALUE,
    // Serial link
    input  wire logic        SHIFT_CLK,
    output logic             READY_AND_SERIAL_OUT,
    // Status
    output logic             CAL_DONE,
    output logic             CONV_START
);
    asr_pkg::asr_state_type state;
    logic                   sys_rise;
    logic                   shift_rise;
    logic [asr_pkg::CNT_W-1:0] sys_cnt;
    logic                   update;
    logic [23:0]            hold;
    logic [23:0]            next_code;
    logic [asr_pkg::EDGE_W-1:0] edge_cnt;
    logic                   reading;

    // System clock pin edges
    asr_sync u_sys_sync (
        .CLK   (CLK),
        .RST_N (RST_N),
        .CE    (CE),
        .din   (SYS_CLK),
        .dout  (),
        .rise  (sys_rise)
    );

    // Shift clock pin edges
    asr_sync u_shift_sync (
        .CLK   (CLK),
        .RST_N (RST_N),
        .CE    (CE),
        .din   (SHIFT_CLK),
        .dout  (),
        .rise  (shift_rise)
    );

    // Clip wide filter value into 24-bit two's complement
    always_comb begin
        if (!FILTER_VALUE[25] && (FILTER_VALUE[24:23] != 2'b00)) begin
            next_code = asr_pkg::CODE_POS_FULL; // R06
        end else if (FILTER_VALUE[25] && (FILTER_VALUE[24:23] != 2'b11)) begin
            next_code = asr_pkg::CODE_NEG_FULL; // R06
        end else begin
            next_code = FILTER_VALUE[23:0]; // R05 R07
        end
    end

    // Calibration then continuous conversion, timed in system clocks
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state   <= asr_pkg::ST_CAL;
            sys_cnt <= '0;
            update  <= 1'b0;
        end else if (CE) begin
            update <= 1'b0;
            if (sys_rise) begin
                case (state)
                    asr_pkg::ST_CAL: begin
                        if (sys_cnt == asr_pkg::CNT_W'(asr_pkg::CAL_SYSCLK - 1)) begin
                            state   <= asr_pkg::ST_CONVERT; // R11
                            sys_cnt <= '0;
                            update  <= 1'b1;
                        end else begin
                            sys_cnt <= sys_cnt + 1'b1;
                        end
                    end
                    default: begin
                        if (sys_cnt == asr_pkg::CNT_W'(asr_pkg::CONV_PERIOD_SYSCLK - 1)) begin
                            sys_cnt <= '0;
                            update  <= 1'b1; // R09
                        end else begin
                            sys_cnt <= sys_cnt + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Held result, replaced at every update
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold <= asr_pkg::HOLD_RESET;
        end else if (CE && update) begin
            hold <= next_code; // R08
        end
    end

    // Shared output: ready low, then shift bits, then forced high
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            READY_AND_SERIAL_OUT <= asr_pkg::OUT_RESET;
            edge_cnt             <= '0;
            reading              <= 1'b0;
        end else if (CE) begin
            if (update) begin
                READY_AND_SERIAL_OUT <= 1'b0; // R01 R14
                edge_cnt             <= '0;
                reading              <= 1'b1;
            end else if (reading && shift_rise) begin
                if (edge_cnt == asr_pkg::EDGE_FORCE) begin
                    READY_AND_SERIAL_OUT <= 1'b1; // R04
                    reading              <= 1'b0;
                end else begin
                    READY_AND_SERIAL_OUT <= hold[5'd23 - edge_cnt]; // R02 R03
                    edge_cnt             <= edge_cnt + 1'b1;
                end
            end
            // Otherwise output holds its last bit R15
        end
    end

    // Status flags
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CAL_DONE   <= 1'b0;
            CONV_START <= 1'b0;
        end else if (CE) begin
            CAL_DONE   <= (state == asr_pkg::ST_CONVERT);
            CONV_START <= update; // R14
        end
    end

    // Converter clock rises since the last update, watched by the rate checks
    logic [asr_pkg::CNT_W-1:0] rate_cnt;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rate_cnt <= '0;
        end else if (CE && update) begin
            rate_cnt <= '0;
        end else if (CE && sys_rise) begin
            rate_cnt <= rate_cnt + 1'b1;
        end
    end

    // Assertions: ready flag and serial sequence
    a_ready_low: assert property (@(posedge CLK) disable iff (!RST_N) // R01
        CE && update |=> !READY_AND_SERIAL_OUT)
        else $error("output not low after update");
    a_msb_first: assert property (@(posedge CLK) disable iff (!RST_N) // R02
        CE && reading && !update && shift_rise && edge_cnt == 5'h00 |=> READY_AND_SERIAL_OUT == $past(hold[23]))
        else $error("msb not presented");
    a_next_bit: assert property (@(posedge CLK) disable iff (!RST_N) // R03
        CE && reading && !update && shift_rise && edge_cnt < 5'h18 |=> edge_cnt == $past(edge_cnt) + 5'h01)
        else $error("bit index did not advance");
    a_force_high: assert property (@(posedge CLK) disable iff (!RST_N) // R04
        CE && reading && !update && shift_rise && edge_cnt == 5'h18 |=> READY_AND_SERIAL_OUT && !reading)
        else $error("output not forced high");
    a_stay_high: assert property (@(posedge CLK) disable iff (!RST_N) // R04
        CE && !reading && !update && READY_AND_SERIAL_OUT |=> READY_AND_SERIAL_OUT)
        else $error("output left high state without update");
    a_hold_last: assert property (@(posedge CLK) disable iff (!RST_N) // R15
        CE && !update && !shift_rise |=> $stable(READY_AND_SERIAL_OUT))
        else $error("output changed without cause");

    // Assertions: result codes and held word
    a_zero_code: assert property (@(posedge CLK) disable iff (!RST_N) // R05
        CE && update && FILTER_VALUE == 26'h0000000 |=> hold == asr_pkg::CODE_ZERO)
        else $error("zero input not zero code");
    a_clip_pos: assert property (@(posedge CLK) disable iff (!RST_N) // R06
        CE && update && ($signed(FILTER_VALUE) > $signed(26'h07fffff)) |=> hold == asr_pkg::CODE_POS_FULL)
        else $error("positive clip wrong");
    a_clip_neg: assert property (@(posedge CLK) disable iff (!RST_N) // R06
        CE && update && ($signed(FILTER_VALUE) < $signed(26'h3800000)) |=> hold == asr_pkg::CODE_NEG_FULL)
        else $error("negative clip wrong");
    a_small_code: assert property (@(posedge CLK) disable iff (!RST_N) // R07
        FILTER_VALUE == 26'h3ffffff |-> next_code == 24'hffffff)
        else $error("minus one code wrong");
    a_result_overwrite: assert property (@(posedge CLK) disable iff (!RST_N) // R08
        CE && update |=> hold == $past(next_code))
        else $error("held result not replaced");

    // Assertions: calibration, status and result rate
    a_cal_first: assert property (@(posedge CLK) disable iff (!RST_N) // R11
        state == asr_pkg::ST_CAL && !update |-> READY_AND_SERIAL_OUT)
        else $error("ready before calibration");
    a_cal_flag: assert property (@(posedge CLK) disable iff (!RST_N) // R11
        CE && update |=> CAL_DONE)
        else $error("calibration flag missing at ready");
    a_start_pulse: assert property (@(posedge CLK) disable iff (!RST_N) // R14
        CE && update |=> CONV_START)
        else $error("conversion start not flagged");
    a_start_once: assert property (@(posedge CLK) disable iff (!RST_N) // R14
        CE && CONV_START |=> !CONV_START)
        else $error("conversion start longer than one cycle");
    a_rate_period: assert property (@(posedge CLK) disable iff (!RST_N) // R09
        CE && update && CAL_DONE |-> rate_cnt == asr_pkg::CNT_W'(asr_pkg::CONV_PERIOD_SYSCLK))
        else $error("update spacing wrong");
    a_rate_bound: assert property (@(posedge CLK) disable iff (!RST_N) // R09
        CE && CAL_DONE && !update |-> rate_cnt < asr_pkg::CNT_W'(asr_pkg::CONV_PERIOD_SYSCLK))
        else $error("update overdue");

    // Assertions: clock enable freezes state
    a_ce_freeze: assert property (@(posedge CLK) disable iff (!RST_N)
        !CE |=> $stable(READY_AND_SERIAL_OUT) && $stable(hold) && $stable(edge_cnt))
        else $error("state moved while enable low");

    // Main scenarios
    c_first_ready: cover property (@(posedge CLK) disable iff (!RST_N) update && state == asr_pkg::ST_CONVERT);
    c_full_read:   cover property (@(posedge CLK) disable iff (!RST_N) reading && shift_rise && edge_cnt == 5'h18);
    c_part_read:   cover property (@(posedge CLK) disable iff (!RST_N) reading && edge_cnt == 5'h05 && update);
    c_clip:        cover property (@(posedge CLK) disable iff (!RST_N) update && next_code == 24'h800000);
    c_ce_pause:    cover property (@(posedge CLK) disable iff (!RST_N) !CE && reading);
endmodule : asr_readout

// ### sim/asr_host.sv
// Host model: drives the serial shift clock and gathers result bits.
// Assumes the shift clock idles low at power-up and between frames.
`timescale 1ns/1ps
module asr_host (
    // Serial link
    output logic      SHIFT_CLK,
    input  wire logic READY_AND_SERIAL_OUT
);
    // Idle low through power-up and between frames
    initial SHIFT_CLK = 1'b0;
    // Shift n rises at 320 ns; sample late in the low phase
    task automatic shift_bits(input int n, output logic [23:0] word, output logic last);
        word = 24'h000000;
        last = 1'b0;
        #7;
        for (int i = 0; i < n; i++) begin
            SHIFT_CLK = 1'b1;
            #160;
            SHIFT_CLK = 1'b0;
            #159;
            last = READY_AND_SERIAL_OUT;
            if (i < 24) word = {word[22:0], last};
            #1;
        end
    endtask : shift_bits
endmodule : asr_host

// ### sim/asr_readout_bench.sv
// Bench for the readout: power-up calibration, clipping, serial reads.
// Assumes the host model owns the shift clock; CE is high except one pause.
`timescale 1ns/1ps
module asr_readout_bench;
    logic        CLK = 1'b0;
    logic        RST_N;
    logic        CE;
    logic        SYS_CLK = 1'b0;
    logic [25:0] FILTER_VALUE;
    logic        SHIFT_CLK;
    logic        READY_AND_SERIAL_OUT;
    logic        CAL_DONE;
    logic        CONV_START;
    logic [1:0]  sys_div = 2'h0;
    logic [23:0] word;
    logic        last;
    int          sys_rises;
    int          mismatches;
    int          n_compared;

    // Core clock, 40 ns
    always #20 CLK = ~CLK;
    // Converter clock at a quarter of the core rate, never stopped
    always @(posedge CLK) begin
        sys_div <= sys_div + 2'h1;
        SYS_CLK <= sys_div[1];
    end
    // Converter clock rises since reset release
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) sys_rises <= 0;
        else sys_rises <= sys_rises + 1;
    end

    asr_readout uut (.CLK(CLK), .RST_N(RST_N), .CE(CE), .SYS_CLK(SYS_CLK), .FILTER_VALUE(FILTER_VALUE),
        .SHIFT_CLK(SHIFT_CLK), .READY_AND_SERIAL_OUT(READY_AND_SERIAL_OUT), .CAL_DONE(CAL_DONE),
        .CONV_START(CONV_START));
    asr_host host (.SHIFT_CLK(SHIFT_CLK), .READY_AND_SERIAL_OUT(READY_AND_SERIAL_OUT));

    // Verdict and end of run
    task automatic final_report();
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Compare and count
    task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Reset with a filter value, then wait for the first ready low
    task automatic power_up(input logic [25:0] v);
        int n;
        @(posedge CLK);
        FILTER_VALUE <= v;
        RST_N <= 1'b0;
        repeat (8) @(posedge CLK);
        @(negedge CLK);
        check("out_in_reset", 24'h1, {23'h0, READY_AND_SERIAL_OUT});
        check("cal_in_reset", 24'h0, {23'h0, CAL_DONE});
        check("start_in_reset", 24'h0, {23'h0, CONV_START});
        @(posedge CLK);
        RST_N <= 1'b1;
        n = 0;
        while (READY_AND_SERIAL_OUT !== 1'b0 && n < 20000) begin
            @(negedge CLK);
            n++;
        end
        if (n >= 20000) begin
            check("ready_low", 24'h0, {23'h0, READY_AND_SERIAL_OUT});
            final_report();
        end
        check("cal_done", 24'h1, {23'h0, CAL_DONE});
        check("conv_start", 24'h1, {23'h0, CONV_START});
        n_compared++;
        if (sys_rises < 4096 || sys_rises > 4098) begin
            mismatches++;
            $display("mismatch cal_rises expected 4096 seen %0d", sys_rises);
        end
        @(negedge CLK);
        check("conv_start_end", 24'h0, {23'h0, CONV_START});
    endtask : power_up

    // Full 25-rise read of one result
    task automatic read_full(input logic [25:0] v, input logic [23:0] exp);
        power_up(v);
        host.shift_bits(25, word, last);
        check("word", exp, word);
        check("forced_high", 24'h1, {23'h0, last});
        repeat (50) @(negedge CLK);
        check("stays_high", 24'h1, {23'h0, READY_AND_SERIAL_OUT});
    endtask : read_full

    // Ten-bit read; output must hold the tenth bit
    task automatic read_partial();
        power_up(26'h0123456);
        host.shift_bits(10, word, last);
        check("partial", 24'h000048, word);
        check("held_bit", 24'h0, {23'h0, last});
        repeat (100) @(negedge CLK);
        check("still_held", 24'h0, {23'h0, READY_AND_SERIAL_OUT});
        // Shift edges while the enable is low must be ignored
        @(posedge CLK);
        CE <= 1'b0;
        host.shift_bits(2, word, last);
        check("frozen", 24'h000000, word);
        @(posedge CLK);
        CE <= 1'b1;
        host.shift_bits(2, word, last);
        check("resumed", 24'h000003, word);
    endtask : read_partial

    // Main sequence
    initial begin
        RST_N = 1'b0;
        CE = 1'b1;
        FILTER_VALUE = 26'h0000000;
        mismatches = 0;
        n_compared = 0;
        read_full(26'h0800000, 24'h7fffff);
        read_full(26'h3000000, 24'h800000);
        read_full(26'h0000001, 24'h000001);
        read_full(26'h3ffffff, 24'hffffff);
        read_partial();
        final_report();
    end
endmodule : asr_readout_bench
